// file: dsc_pkg.sv
// Purpose: constants and types for the sample clock and pll configuration block
// Assumes: byte-wide registers behind the serial port, 12-bit register address
// Notes: reset values follow the power-down-by-default behaviour
package dsc_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [11:0] OFS_CLK_PWR = 12'h080;
	localparam logic [11:0] OFS_PLL_CTRL = 12'h083;
	localparam logic [11:0] OFS_PLL_STAT = 12'h084;
	localparam logic [11:0] OFS_FB_RATIO = 12'h085;
	localparam logic [11:0] OFS_LF_A = 12'h087;
	localparam logic [11:0] OFS_LF_B = 12'h088;
	localparam logic [11:0] OFS_LF_C = 12'h089;
	localparam logic [11:0] OFS_CP_CUR = 12'h08A;
	localparam logic [11:0] OFS_OUT_DIV = 12'h08B;
	localparam logic [11:0] OFS_REF_DIV = 12'h08C;
	localparam logic [11:0] OFS_REGUL = 12'h08D;
	localparam logic [11:0] OFS_BLK_PWR = 12'h1B0;
	localparam logic [11:0] OFS_CP_B = 12'h1B9;
	localparam logic [11:0] OFS_OSC_CTL = 12'h1BC;
	localparam logic [11:0] OFS_OSC_PWR = 12'h1BE;
	localparam logic [11:0] OFS_OSC_CAL = 12'h1BF;
	localparam logic [11:0] OFS_LOCK_CNT = 12'h1C0;
	localparam logic [11:0] OFS_CP_C = 12'h1C1;
	localparam logic [11:0] OFS_VARACTOR = 12'h1C4;
	localparam int NUM_CFG = 12;

	// field positions
	localparam int PWR_DAC01_BIT = 7;
	localparam int PWR_DAC23_BIT = 6;
	localparam int PWR_DIG_BIT = 5;
	localparam int PWR_SER_BIT = 4;
	localparam int PWR_RCV_BIT = 3;
	localparam int CTRL_RECAL_BIT = 7;
	localparam int CTRL_EN_BIT = 4;
	localparam int STAT_BAND_HI_BIT = 7;
	localparam int STAT_BAND_LO_BIT = 6;
	localparam int STAT_CAL_DONE_BIT = 5;
	localparam int STAT_LOCK_BIT = 1;
	localparam int CP_CUR_W = 6;
	localparam int REF_CODE_W = 3;
	localparam int OUT_CODE_W = 2;

	// reset values
	localparam logic [7:0] RST_CLK_PWR = 8'hF8;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// feedback ratio limits and divider encodings
	localparam logic [7:0] FB_MIN = 8'h06;
	localparam logic [7:0] FB_MAX = 8'h7F;
	localparam logic [2:0] REF_CODE_MAX = 3'h4;
	localparam logic [5:0] REF_FACTOR_32 = 6'h20;
	localparam logic [4:0] OUT_FACTOR_4 = 5'h04;
	localparam logic [4:0] OUT_FACTOR_8 = 5'h08;
	localparam logic [4:0] OUT_FACTOR_16 = 5'h10;

	// calibration length in reference clock cycles
	localparam logic [6:0] CAL_REF_CYCLES = 7'h40;

	typedef enum logic [1:0] {
		CAL_IDLE,
		CAL_RUN,
		CAL_DONE
	} dsc_cal_state_t;
endpackage : dsc_pkg

// file: dsc_clock_config.sv
// Purpose: sample clock source, pll divider, power-up and charge pump calibration control
// Assumes: register port is the decoded side of the serial port, on clk_in
// Notes: pll analog status and the reference tap arrive asynchronously
// Notes on behaviour
// - direct clock or pll multiplied sample clock
// - pll output drives all internal clocks
// - clock domains and receiver powered down after reset
// - power bits seven to three map domains
// - reference divider codes zero to four
// - feedback ratio eight bits, six to 127
// - output divider codes one to three
// - calibrate once, keep coefficient for restarts
// - calibration on by default, 64 reference cycles
// - status bit five shows calibration done
// - charge pump current six-bit code
// - five four-bit loop filter codes, three registers
// - status bit one reports pll lock
// - band edge flags; recalibrate by zero then one
`timescale 1ns/100ps
module dsc_clock_config (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [11:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic pll_reference_input_in,
	input wire logic pll_lock_in,
	input wire logic band_high_in,
	input wire logic band_low_in,
	input wire logic cp_cal_enable_in,
	output logic [7:0] reg_rdata_out,
	output logic clk_en_dac01_out,
	output logic clk_en_dac23_out,
	output logic clk_en_digital_out,
	output logic clk_en_serdes_out,
	output logic clk_en_receiver_out,
	output logic pll_enable_out,
	output logic sample_clock_from_pll_out,
	output logic [5:0] reference_divide_factor_out,
	output logic [7:0] feedback_divide_ratio_out,
	output logic [4:0] output_divide_factor_out,
	output logic [5:0] cp_current_code_out,
	output logic [23:0] loop_filter_codes_out,
	output logic cp_cal_running_out,
	output logic vco_recal_out
);
	////////////////////////////////////////////////////////////////////////////////
	// register file
	logic [7:0] pwr_r;
	logic [7:0] ctrl_r;
	logic [7:0] fb_r;
	logic [7:0] cfg_r [dsc_pkg::NUM_CFG];
	logic [7:0] out_div_r;
	logic [7:0] ref_div_r;
	logic [7:0] stat_nxt;
	logic [7:0] rdata_nxt;
	int cfg_idx;

	// index of the plain storage registers, 12 for the varactor, -1 for any other address
	always_comb begin
		cfg_idx = -1;
		if (reg_addr_in == dsc_pkg::OFS_LF_A) begin
			cfg_idx = 0;
		end else if (reg_addr_in == dsc_pkg::OFS_LF_B) begin
			cfg_idx = 1;
		end else if (reg_addr_in == dsc_pkg::OFS_LF_C) begin
			cfg_idx = 2;
		end else if (reg_addr_in == dsc_pkg::OFS_CP_CUR) begin
			cfg_idx = 3;
		end else if (reg_addr_in == dsc_pkg::OFS_REGUL) begin
			cfg_idx = 4;
		end else if (reg_addr_in == dsc_pkg::OFS_BLK_PWR) begin
			cfg_idx = 5;
		end else if (reg_addr_in == dsc_pkg::OFS_CP_B) begin
			cfg_idx = 6;
		end else if (reg_addr_in == dsc_pkg::OFS_OSC_CTL) begin
			cfg_idx = 7;
		end else if (reg_addr_in == dsc_pkg::OFS_OSC_PWR) begin
			cfg_idx = 8;
		end else if (reg_addr_in == dsc_pkg::OFS_OSC_CAL) begin
			cfg_idx = 9;
		end else if (reg_addr_in == dsc_pkg::OFS_LOCK_CNT) begin
			cfg_idx = 10;
		end else if (reg_addr_in == dsc_pkg::OFS_CP_C) begin
			cfg_idx = 11;
		end else if (reg_addr_in == dsc_pkg::OFS_VARACTOR) begin
			cfg_idx = 12;
		end
	end

	// varactor sits one past the storage array, so it keeps a register of its own
	logic [7:0] varactor_r;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pwr_r <= dsc_pkg::RST_CLK_PWR;
			ctrl_r <= dsc_pkg::RST_ZERO;
			fb_r <= dsc_pkg::RST_ZERO;
			out_div_r <= dsc_pkg::RST_ZERO;
			ref_div_r <= dsc_pkg::RST_ZERO;
			varactor_r <= dsc_pkg::RST_ZERO;
			for (int i = 0; i < dsc_pkg::NUM_CFG; i++) begin
				cfg_r[i] <= dsc_pkg::RST_ZERO;
			end
		end else if (reg_wr_in) begin
			if (reg_addr_in == dsc_pkg::OFS_CLK_PWR) begin
				pwr_r <= reg_wdata_in;
			end else if (reg_addr_in == dsc_pkg::OFS_PLL_CTRL) begin
				ctrl_r <= reg_wdata_in;
			end else if (reg_addr_in == dsc_pkg::OFS_FB_RATIO) begin
				fb_r <= reg_wdata_in;
			end else if (reg_addr_in == dsc_pkg::OFS_OUT_DIV) begin
				out_div_r <= reg_wdata_in;
			end else if (reg_addr_in == dsc_pkg::OFS_REF_DIV) begin
				ref_div_r <= reg_wdata_in;
			end else if (reg_addr_in == dsc_pkg::OFS_VARACTOR) begin
				varactor_r <= reg_wdata_in;
			end else if (cfg_idx >= 0 && cfg_idx < dsc_pkg::NUM_CFG) begin
				cfg_r[cfg_idx] <= reg_wdata_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// synchronisers for pins from the analog pll side
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic ref_prev_r;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
			ref_prev_r <= 1'b0;
		end else begin
			sync1_r <= {pll_reference_input_in, pll_lock_in, band_high_in, band_low_in};
			sync2_r <= sync1_r;
			ref_prev_r <= sync2_r[3];
		end
	end

	// the reference is seen through a 50 MHz sampler, so only a slow tap of it can be counted
	logic ref_edge;
	assign ref_edge = sync2_r[3] && !ref_prev_r;

	////////////////////////////////////////////////////////////////////////////////
	// charge pump calibration
	dsc_pkg::dsc_cal_state_t cal_state_r;
	logic [6:0] cal_cnt_r;
	logic pll_en;
	assign pll_en = ctrl_r[dsc_pkg::CTRL_EN_BIT];

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cal_state_r <= dsc_pkg::CAL_IDLE;
			cal_cnt_r <= 7'h00;
		end else begin
			case (cal_state_r)
				dsc_pkg::CAL_IDLE: begin
					cal_cnt_r <= 7'h00;
					if (pll_en && cp_cal_enable_in) begin
						cal_state_r <= dsc_pkg::CAL_RUN;
					end
				end
				dsc_pkg::CAL_RUN: begin
					// a pll switched off mid-run leaves no valid coefficient, so restart later
					if (!pll_en) begin
						cal_state_r <= dsc_pkg::CAL_IDLE;
					end else if (ref_edge) begin
						cal_cnt_r <= cal_cnt_r + 7'h01;
						if (cal_cnt_r == dsc_pkg::CAL_REF_CYCLES - 7'h01) begin
							cal_state_r <= dsc_pkg::CAL_DONE;
						end
					end
				end
				dsc_pkg::CAL_DONE: begin
					cal_state_r <= dsc_pkg::CAL_DONE;
				end
				default: begin
					cal_state_r <= dsc_pkg::CAL_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status and readback
	always_comb begin
		stat_nxt = 8'h00;
		stat_nxt[dsc_pkg::STAT_BAND_HI_BIT] = pll_en && sync2_r[1];
		stat_nxt[dsc_pkg::STAT_BAND_LO_BIT] = pll_en && sync2_r[0];
		stat_nxt[dsc_pkg::STAT_CAL_DONE_BIT] = (cal_state_r == dsc_pkg::CAL_DONE);
		stat_nxt[dsc_pkg::STAT_LOCK_BIT] = pll_en && sync2_r[2];
	end

	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_addr_in == dsc_pkg::OFS_CLK_PWR) begin
			rdata_nxt = pwr_r;
		end else if (reg_addr_in == dsc_pkg::OFS_PLL_CTRL) begin
			rdata_nxt = ctrl_r;
		end else if (reg_addr_in == dsc_pkg::OFS_PLL_STAT) begin
			rdata_nxt = stat_nxt;
		end else if (reg_addr_in == dsc_pkg::OFS_FB_RATIO) begin
			rdata_nxt = fb_r;
		end else if (reg_addr_in == dsc_pkg::OFS_OUT_DIV) begin
			rdata_nxt = out_div_r;
		end else if (reg_addr_in == dsc_pkg::OFS_REF_DIV) begin
			rdata_nxt = ref_div_r;
		end else if (reg_addr_in == dsc_pkg::OFS_VARACTOR) begin
			rdata_nxt = varactor_r;
		end else if (cfg_idx >= 0 && cfg_idx < dsc_pkg::NUM_CFG) begin
			rdata_nxt = cfg_r[cfg_idx];
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// clock power enables, a set bit keeps its domain off
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			clk_en_dac01_out <= 1'b0;
			clk_en_dac23_out <= 1'b0;
			clk_en_digital_out <= 1'b0;
			clk_en_serdes_out <= 1'b0;
			clk_en_receiver_out <= 1'b0;
		end else begin
			clk_en_dac01_out <= !pwr_r[dsc_pkg::PWR_DAC01_BIT];
			clk_en_dac23_out <= !pwr_r[dsc_pkg::PWR_DAC23_BIT];
			clk_en_digital_out <= !pwr_r[dsc_pkg::PWR_DIG_BIT];
			clk_en_serdes_out <= !pwr_r[dsc_pkg::PWR_SER_BIT];
			clk_en_receiver_out <= !pwr_r[dsc_pkg::PWR_RCV_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// divider settings and source select
	logic [2:0] ref_code;
	logic [1:0] out_code;
	assign ref_code = ref_div_r[dsc_pkg::REF_CODE_W-1:0];
	assign out_code = out_div_r[dsc_pkg::OUT_CODE_W-1:0];

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pll_enable_out <= 1'b0;
			sample_clock_from_pll_out <= 1'b0;
			reference_divide_factor_out <= 6'h01;
			feedback_divide_ratio_out <= dsc_pkg::FB_MIN;
			output_divide_factor_out <= dsc_pkg::OUT_FACTOR_4;
			cp_current_code_out <= 6'h00;
			loop_filter_codes_out <= 24'h000000;
		end else begin
			pll_enable_out <= pll_en;
			sample_clock_from_pll_out <= pll_en;
			if (ref_code <= dsc_pkg::REF_CODE_MAX) begin
				reference_divide_factor_out <= 6'h01 << ref_code;
			end else begin
				reference_divide_factor_out <= dsc_pkg::REF_FACTOR_32;
			end
			if (fb_r < dsc_pkg::FB_MIN) begin
				feedback_divide_ratio_out <= dsc_pkg::FB_MIN;
			end else if (fb_r > dsc_pkg::FB_MAX) begin
				feedback_divide_ratio_out <= dsc_pkg::FB_MAX;
			end else begin
				feedback_divide_ratio_out <= fb_r;
			end
			case (out_code)
				2'h2: output_divide_factor_out <= dsc_pkg::OUT_FACTOR_8;
				2'h3: output_divide_factor_out <= dsc_pkg::OUT_FACTOR_16;
				default: output_divide_factor_out <= dsc_pkg::OUT_FACTOR_4;
			endcase
			cp_current_code_out <= cfg_r[3][dsc_pkg::CP_CUR_W-1:0];
			loop_filter_codes_out <= {cfg_r[2], cfg_r[1], cfg_r[0]};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// calibration run flag and band recalibration pulse
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cp_cal_running_out <= 1'b0;
			vco_recal_out <= 1'b0;
		end else begin
			cp_cal_running_out <= (cal_state_r == dsc_pkg::CAL_RUN);
			vco_recal_out <= reg_wr_in && reg_addr_in == dsc_pkg::OFS_PLL_CTRL
				&& !ctrl_r[dsc_pkg::CTRL_RECAL_BIT]
				&& reg_wdata_in[dsc_pkg::CTRL_RECAL_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	AST_PWR_RESET: assert property (@(posedge clk_in) disable iff (!resetn_in)
		$rose(resetn_in) |-> !clk_en_receiver_out)
		else $error("receiver clock enabled straight after reset");
	AST_PWR_MAP: assert property (@(posedge clk_in) disable iff (!resetn_in)
		reg_wr_in && reg_addr_in == dsc_pkg::OFS_CLK_PWR |-> ##2
		clk_en_dac01_out == !$past(reg_wdata_in[7], 2)
		&& clk_en_receiver_out == !$past(reg_wdata_in[3], 2))
		else $error("clock enables do not follow power register");
	AST_CAL_LEN: assert property (@(posedge clk_in) disable iff (!resetn_in)
		cal_state_r == dsc_pkg::CAL_RUN && cal_state_r != $past(cal_state_r) |->
		cal_cnt_r == 7'h00)
		else $error("calibration counter not cleared on start");
	AST_CAL_COUNT: assert property (@(posedge clk_in) disable iff (!resetn_in)
		$rose(cal_state_r == dsc_pkg::CAL_DONE) |-> $past(cal_cnt_r) == 7'h3F)
		else $error("calibration ended before 64 reference cycles");
	AST_CAL_KEEP: assert property (@(posedge clk_in) disable iff (!resetn_in)
		cal_state_r == dsc_pkg::CAL_DONE |=> cal_state_r == dsc_pkg::CAL_DONE [*8])
		else $error("calibration result lost");
	AST_DONE_FLAG: assert property (@(posedge clk_in) disable iff (!resetn_in)
		reg_rd_in && reg_addr_in == dsc_pkg::OFS_PLL_STAT |=>
		reg_rdata_out[5] == $past(cal_state_r == dsc_pkg::CAL_DONE))
		else $error("status bit five disagrees with calibration");
	AST_FB_RANGE: assert property (@(posedge clk_in) disable iff (!resetn_in)
		feedback_divide_ratio_out >= dsc_pkg::FB_MIN
		&& feedback_divide_ratio_out <= dsc_pkg::FB_MAX)
		else $error("feedback ratio outside 6 to 127");
	AST_REF_MAP: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ref_code == 3'h3 ##1 ref_code == 3'h3 |-> reference_divide_factor_out == 6'h08)
		else $error("reference code three not divide by eight");
	AST_OUT_MAP: assert property (@(posedge clk_in) disable iff (!resetn_in)
		out_code == 2'h3 |=> output_divide_factor_out == dsc_pkg::OUT_FACTOR_16)
		else $error("output code three not divide by sixteen");
	AST_RECAL: assert property (@(posedge clk_in) disable iff (!resetn_in)
		vco_recal_out |-> ctrl_r[7] && !$past(ctrl_r[7]))
		else $error("recalibration pulse without zero to one write");
	AST_LOCK: assert property (@(posedge clk_in) disable iff (!resetn_in)
		reg_rd_in && reg_addr_in == dsc_pkg::OFS_PLL_STAT && !pll_en |=>
		!reg_rdata_out[dsc_pkg::STAT_LOCK_BIT])
		else $error("lock reported while pll disabled");
	AST_SRC: assert property (@(posedge clk_in) disable iff (!resetn_in)
		$rose(pll_en) |=> sample_clock_from_pll_out)
		else $error("sample clock source did not follow pll enable");
endmodule : dsc_clock_config

// file: dsc_ref_source.sv
// Purpose: slow reference clock tap feeding the clock block
// Assumes: the bench starts it only while a calibration run is wanted
// Notes: held low while stopped so no stray edge reaches the edge counter
`timescale 1ns/100ps
module dsc_ref_source #(
	parameter int HALF_NS = 100
) (
	input wire logic run_in,
	output logic ref_out
);
	// 5 MHz tap, well under the sync limit of the 50 MHz core clock
	initial begin
		ref_out = 1'b0;
		forever begin
			#(HALF_NS);
			ref_out = run_in ? ~ref_out : 1'b0;
		end
	end
endmodule : dsc_ref_source

// file: dsc_clock_config_tb.sv
// Purpose: self-checking bench for the sample clock configuration block
// Assumes: registers reached through the decoded strobe port, inputs driven at falling edge
// Notes: a register model in an associative array predicts every read and the outputs checked in chk_outs
`timescale 1ns/100ps
module dsc_clock_config_tb;
	logic clk_in, resetn_in, wr, rd, lock, bhi, blo, run, refck;
	logic [11:0] addr;
	logic [7:0] wdata, rdata, fb;
	logic [5:0] refd, cp;
	logic [4:0] outd;
	logic [23:0] lf;
	logic e0, e1, e2, e3, e4, pen, spll, calr, recal;
	logic [31:0] seed;
	logic [7:0] mdl [int];
	logic [11:0] ofs [19] = '{12'h080, 12'h083, 12'h085, 12'h087, 12'h088, 12'h089, 12'h08A,
		12'h08B, 12'h08C, 12'h08D, 12'h1B0, 12'h1B9, 12'h1BC, 12'h1BE, 12'h1BF, 12'h1C0,
		12'h1C1, 12'h1C4, 12'h084};
	int fbl [8] = '{5, 6, 7, 126, 127, 128, 0, 255};
	int mismatches, compares, pulses, n;
	bit cal_done;

	dsc_clock_config DUT (.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .pll_reference_input_in(refck),
		.pll_lock_in(lock), .band_high_in(bhi), .band_low_in(blo), .cp_cal_enable_in(1'b1),
		.reg_rdata_out(rdata), .clk_en_dac01_out(e0), .clk_en_dac23_out(e1),
		.clk_en_digital_out(e2), .clk_en_serdes_out(e3), .clk_en_receiver_out(e4),
		.pll_enable_out(pen), .sample_clock_from_pll_out(spll),
		.reference_divide_factor_out(refd), .feedback_divide_ratio_out(fb),
		.output_divide_factor_out(outd), .cp_current_code_out(cp),
		.loop_filter_codes_out(lf), .cp_cal_running_out(calr), .vco_recal_out(recal));
	dsc_ref_source #(.HALF_NS(100)) ref_src (.run_in(run), .ref_out(refck));

	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	// pulse counter sampled where the registered pulse has settled
	always @(negedge clk_in) begin
		if (recal === 1'b1) pulses++;
	end
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : xs
	// band and lock are masked by the enable bit, so stale analog levels never leak out
	function automatic logic [7:0] exp_stat();
		logic en;
		en = mdl[12'h083][4];
		return {en & bhi, en & blo, cal_done, 3'h0, en & lock, 1'h0};
	endfunction : exp_stat
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t read %h expected %h", $time, got, exp);
		end
	endtask : chk8
	task automatic chk_out(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t output %h expected %h", $time, got, exp);
		end
	endtask : chk_out
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk_in);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk_in);
		wr = 1'b0;
		if (mdl.exists(a) && a != 12'h084) mdl[a] = d;
	endtask : wr_reg
	task automatic rd_chk(input logic [11:0] a);
		logic [7:0] e;
		@(negedge clk_in);
		addr = a;
		rd = 1'b1;
		@(negedge clk_in);
		rd = 1'b0;
		e = (a == 12'h084) ? exp_stat() : (mdl.exists(a) ? mdl[a] : 8'h00);
		chk8(rdata, e);
	endtask : rd_chk
	task automatic chk_outs();
		logic [7:0] p, c, f;
		logic [2:0] rc;
		logic [1:0] oc;
		logic [4:0] pw;
		@(negedge clk_in);
		p = mdl[12'h080];
		// inverted in five bits so the widening cast below cannot set the upper bits
		pw = ~p[7:3];
		c = mdl[12'h083];
		f = mdl[12'h085];
		rc = mdl[12'h08C][2:0];
		oc = mdl[12'h08B][1:0];
		chk_out(24'({e0, e1, e2, e3, e4}), 24'(pw));
		chk_out(24'(pen), 24'(c[4]));
		chk_out(24'(spll), 24'(c[4]));
		chk_out(24'(refd), (rc > 3'h4) ? 24'h20 : 24'h1 << rc);
		chk_out(24'(fb), (f < 8'h06) ? 24'h6 : (f > 8'h7F) ? 24'h7F : 24'(f));
		chk_out(24'(outd), (oc == 2'h3) ? 24'h10 : (oc == 2'h2) ? 24'h8 : 24'h4);
		chk_out(24'(cp), 24'(mdl[12'h08A][5:0]));
		chk_out(lf, {mdl[12'h089], mdl[12'h088], mdl[12'h087]});
	endtask : chk_outs
	task automatic final_report();
		$display("counts mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h311C;
		mismatches = 0;
		compares = 0;
		pulses = 0;
		cal_done = 1'b0;
		{resetn_in, wr, rd, lock, bhi, blo, run} = 7'h00;
		addr = 12'h000;
		wdata = 8'h00;
		foreach (ofs[i]) mdl[ofs[i]] = 8'h00;
		mdl[12'h080] = 8'hF8;
		repeat (8) @(posedge clk_in);
		@(negedge clk_in);
		resetn_in = 1'b1;
		chk_outs();
		foreach (ofs[i]) rd_chk(ofs[i]);
		rd_chk(12'h081);
		$display("reset values done");
		wr_reg(12'h080, 8'h00);
		chk_outs();
		repeat (6) begin
			wr_reg(12'h080, xs());
			chk_outs();
		end
		wr_reg(12'h080, 8'h00);
		$display("power control done");
		for (int i = 0; i < 8; i++) begin
			wr_reg(12'h08C, 8'(i));
			wr_reg(12'h08B, 8'(i));
			wr_reg(12'h085, 8'(fbl[i]));
			chk_outs();
			rd_chk(12'h085);
		end
		foreach (ofs[i]) wr_reg(ofs[i], (ofs[i] == 12'h083) ? 8'h00 : xs());
		wr_reg(12'h081, 8'h5A);
		foreach (ofs[i]) rd_chk(ofs[i]);
		rd_chk(12'h081);
		chk_outs();
		$display("dividers and storage done");
		wr_reg(12'h087, 8'h62);
		wr_reg(12'h088, 8'hC9);
		wr_reg(12'h089, 8'h0E);
		wr_reg(12'h08A, 8'h12);
		wr_reg(12'h08C, 8'h03);
		wr_reg(12'h083, 8'h10);
		chk_outs();
		repeat (4) @(negedge clk_in);
		chk_out(24'(calr), 24'h1);
		run = 1'b1;
		// about 60 tap edges: must still be short of the full count
		repeat (600) @(negedge clk_in);
		rd_chk(12'h084);
		n = 0;
		while (calr !== 1'b0 && n < 2000) begin
			@(negedge clk_in);
			n++;
		end
		if (n >= 2000) begin
			mismatches++;
			$display("mismatch at %0t calibration wait %h expected %h", $time, n, 0);
		end
		cal_done = 1'b1;
		run = 1'b0;
		rd_chk(12'h084);
		wr_reg(12'h083, 8'h00);
		wr_reg(12'h083, 8'h10);
		repeat (4) @(negedge clk_in);
		chk_out(24'(calr), 24'h0);
		rd_chk(12'h084);
		$display("calibration done");
		lock = 1'b1;
		bhi = 1'b1;
		repeat (3) @(negedge clk_in);
		rd_chk(12'h084);
		bhi = 1'b0;
		blo = 1'b1;
		repeat (3) @(negedge clk_in);
		rd_chk(12'h084);
		wr_reg(12'h084, 8'hFF);
		wr_reg(12'h083, 8'h00);
		rd_chk(12'h084);
		{lock, blo} = 2'h0;
		pulses = 0;
		wr_reg(12'h083, 8'h90);
		repeat (3) @(negedge clk_in);
		chk_out(24'(pulses), 24'h1);
		wr_reg(12'h083, 8'h90);
		repeat (3) @(negedge clk_in);
		chk_out(24'(pulses), 24'h1);
		$display("status and recalibration done");
		final_report();
	end
endmodule : dsc_clock_config_tb
